// ==== pkg/uaux_consts.vh ====
// Constants for the UART auxiliary register bank
// Assumes a Verilog-2005 compiler; included by bare name
`ifndef UAUX_CONSTS_VH
`define UAUX_CONSTS_VH
`define UAUX_IDX_DATA    3'h0
`define UAUX_IDX_IER     3'h1
`define UAUX_IDX_ISR     3'h2
`define UAUX_IDX_LCR     3'h3
`define UAUX_IDX_MCR     3'h4
`define UAUX_IDX_LSR     3'h5
`define UAUX_IDX_MSR     3'h6
`define UAUX_IDX_SPR     3'h7
`define UAUX_IDX_EVST    4'h8
`define UAUX_IDX_EVMSK   4'h9
`define UAUX_IDX_POR     4'ha
`define UAUX_RST_DIVH    8'h00
`define UAUX_RST_DIVL    8'h01
`define UAUX_RST_ZERO    8'h00
`define UAUX_RST_ISR     8'h01
`define UAUX_RST_LSR     8'h60
`define UAUX_RST_SPR     8'hff
`define UAUX_LCR_DLAB    7
`define UAUX_MCR_DTR     0
`define UAUX_MCR_RTS     1
`define UAUX_MCR_OUT1    2
`define UAUX_MCR_OUT2    3
`define UAUX_MCR_LOOP    4
`define UAUX_SAMPLE_DIV  5'h10
`endif

// ==== verilog/uaux_regs.v ====
// Register bank of one UART channel: modem status, scratch, divisor, reset state
// Assumes an Avalon-MM master and pin inputs synchronous to ref_clk
//
// The register offsets and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/10ps
`include "uaux_consts.vh"
module uaux_regs (
    // Clock and resets
    input  wire        ref_clk,
    input  wire        srst,
    input  wire        por,
    // Avalon-MM slave
    input  wire [5:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output wire [31:0] avs_readdata,
    output wire        avs_waitrequest,
    output wire [1:0]  avs_response,
    // Mode straps
    input  wire        bus_mode_68,
    input  wire        irq_drive_select,
    // Modem inputs
    input  wire        clear_to_send_n,
    input  wire        set_ready_n,
    input  wire        ring_indicator_n,
    input  wire        carrier_detect_n,
    // Serial, modem and dma outputs
    output reg         tx_serial_q,
    output wire        request_to_send_n,
    output wire        terminal_ready_n,
    output reg         rx_dma_ready_n_q,
    output reg         tx_dma_ready_n_q,
    // Interrupt pins
    output wire        irq_out,
    output wire        irq_oe,
    output wire        bus68_request_n,
    output wire        event_irq,
    // Baud tick
    output reg         sample_tick_q
);
    reg  [7:0]  ier_q, fcr_q, lcr_q, mcr_q, spr_q, dll_q, dlm_q;
    reg  [3:0]  delta_q;
    reg  [3:0]  modem_prev_q;
    reg  [1:0]  evst_q, evmsk_q;
    reg  [15:0] baud_cnt_q;
    reg  [3:0]  samp_cnt_q;
    reg         ack_q;
    reg  [31:0] rdata_q;
    reg  [31:0] rdata_d;
    reg  [3:0]  modem_now;
    reg  [3:0]  delta_set;
    wire [15:0] divisor;
    wire [3:0]  word_idx;
    wire        loop_en;
    wire        dlab;
    wire        req;
    wire        wr_go;
    wire        rd_go;
    wire        wr_b0;
    wire        mapped;
    wire [7:0]  wb;
    wire [7:0]  msr_val;
    wire        irq_active;
    wire [1:0]  ev_set;
    wire        tick_wrap;
    wire        bit_done;

    assign word_idx = avs_address[5:2];
    assign req      = avs_read | avs_write;
    // One wait cycle, then acknowledge
    assign avs_waitrequest = req & ~ack_q;
    assign wr_go    = avs_write & ack_q;
    assign rd_go    = avs_read & ~ack_q;
    assign wr_b0    = wr_go & avs_byteenable[0];
    assign wb       = avs_writedata[7:0];
    assign mapped   = (word_idx <= `UAUX_IDX_POR);
    assign avs_response = 2'h0;
    assign avs_readdata = rdata_q;
    assign loop_en  = mcr_q[`UAUX_MCR_LOOP];
    assign dlab     = lcr_q[`UAUX_LCR_DLAB];
    assign divisor  = {dlm_q, dll_q};

    always @* begin
        if (loop_en) begin
            modem_now = {mcr_q[`UAUX_MCR_OUT2], mcr_q[`UAUX_MCR_OUT1], mcr_q[`UAUX_MCR_DTR], mcr_q[`UAUX_MCR_RTS]};
        end else begin
            modem_now = ~{carrier_detect_n, ring_indicator_n, set_ready_n, clear_to_send_n};
        end
    end

    // Ring delta only on trailing edge
    always @* begin
        delta_set    = modem_now ^ modem_prev_q;
        delta_set[2] = modem_prev_q[2] & ~modem_now[2];
    end

    assign msr_val = {modem_now, delta_q};

    // Cleared by either reset so no stale answer follows reset
    always @(posedge ref_clk) begin
        if (srst || por) begin
            ack_q <= 1'b0;
        end else if (ack_q) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~srst;
        end
    end

    always @(posedge ref_clk) begin
        if (por) begin
            dlm_q <= `UAUX_RST_DIVH;
            dll_q <= `UAUX_RST_DIVL;
        end else if (wr_b0 && dlab && word_idx == {1'b0, `UAUX_IDX_DATA}) begin
            dll_q <= wb;
        end else if (wr_b0 && dlab && word_idx == {1'b0, `UAUX_IDX_IER}) begin
            dlm_q <= wb;
        end
    end

    // Event 0 is one full bit time of sample ticks
    assign tick_wrap = (baud_cnt_q + 16'h0001 >= divisor);
    assign bit_done  = tick_wrap & (samp_cnt_q == 4'hf);
    assign ev_set    = {|delta_set, bit_done};

    always @(posedge ref_clk) begin
        if (srst || por) begin
            ier_q        <= `UAUX_RST_ZERO;
            fcr_q        <= `UAUX_RST_ZERO;
            lcr_q        <= `UAUX_RST_ZERO;
            mcr_q        <= `UAUX_RST_ZERO;
            spr_q        <= `UAUX_RST_SPR;
            delta_q      <= 4'h0;
            modem_prev_q <= ~{carrier_detect_n, ring_indicator_n, set_ready_n, clear_to_send_n};
            evst_q       <= 2'h0;
            evmsk_q      <= 2'h0;
        end else begin
            modem_prev_q <= modem_now;
            // Set wins over read-clear
            if (rd_go && word_idx == {1'b0, `UAUX_IDX_MSR}) begin
                delta_q <= delta_set;
            end else begin
                delta_q <= delta_q | delta_set;
            end
            // Sticky events, write one clears, set wins
            if (wr_b0 && word_idx == `UAUX_IDX_EVST) begin
                evst_q <= (evst_q & ~wb[1:0]) | ev_set;
            end else begin
                evst_q <= evst_q | ev_set;
            end
            if (wr_b0) begin
                case (word_idx)
                    {1'b0, `UAUX_IDX_IER}: if (!dlab) ier_q <= wb;
                    {1'b0, `UAUX_IDX_ISR}: fcr_q <= wb;
                    {1'b0, `UAUX_IDX_LCR}: lcr_q <= wb;
                    {1'b0, `UAUX_IDX_MCR}: mcr_q <= {3'h0, wb[4:0]};
                    {1'b0, `UAUX_IDX_SPR}: spr_q <= wb;
                    `UAUX_IDX_EVMSK:       evmsk_q <= wb[1:0];
                    default: ;
                endcase
            end
        end
    end

    always @(posedge ref_clk) begin
        if (srst || por) begin
            baud_cnt_q    <= 16'h0000;
            samp_cnt_q    <= 4'h0;
            sample_tick_q <= 1'b0;
        end else if (tick_wrap) begin
            baud_cnt_q    <= 16'h0000;
            samp_cnt_q    <= samp_cnt_q + 4'h1;
            sample_tick_q <= 1'b1;
        end else begin
            baud_cnt_q    <= baud_cnt_q + 16'h0001;
            sample_tick_q <= 1'b0;
        end
    end

    always @(posedge ref_clk) begin
        if (srst || por) begin
            tx_serial_q      <= 1'b1;
            rx_dma_ready_n_q <= 1'b1;
            tx_dma_ready_n_q <= 1'b0;
        end else begin
            // Break forces space on the line
            tx_serial_q      <= ~lcr_q[6];
            rx_dma_ready_n_q <= 1'b1;
            tx_dma_ready_n_q <= 1'b0;
        end
    end

    // modem outputs from control bits, muted in loopback
    assign request_to_send_n = loop_en | ~mcr_q[`UAUX_MCR_RTS];
    assign terminal_ready_n  = loop_en | ~mcr_q[`UAUX_MCR_DTR];

    // Interrupt source shows none pending here, so the pin idles inactive
    assign irq_active = 1'b0;
    assign irq_out    = irq_active;
    assign irq_oe     = ~bus_mode_68 & (irq_drive_select | mcr_q[`UAUX_MCR_OUT2]);
    assign bus68_request_n = ~(bus_mode_68 & irq_active);
    assign event_irq  = |(evst_q & evmsk_q);

    always @* begin
        rdata_d = 32'h00000000;
        case (word_idx)
            {1'b0, `UAUX_IDX_DATA}: rdata_d[7:0] = dlab ? dll_q : 8'h00;
            {1'b0, `UAUX_IDX_IER}:  rdata_d[7:0] = dlab ? dlm_q : ier_q;
            {1'b0, `UAUX_IDX_ISR}:  rdata_d[7:0] = `UAUX_RST_ISR;
            {1'b0, `UAUX_IDX_LCR}:  rdata_d[7:0] = lcr_q;
            {1'b0, `UAUX_IDX_MCR}:  rdata_d[7:0] = mcr_q;
            {1'b0, `UAUX_IDX_LSR}:  rdata_d[7:0] = `UAUX_RST_LSR;
            {1'b0, `UAUX_IDX_MSR}:  rdata_d[7:0] = msr_val;
            {1'b0, `UAUX_IDX_SPR}:  rdata_d[7:0] = spr_q;
            `UAUX_IDX_EVST:         rdata_d[1:0] = evst_q;
            `UAUX_IDX_EVMSK:        rdata_d[1:0] = evmsk_q;
            `UAUX_IDX_POR:          rdata_d[15:0] = divisor;
            default:                rdata_d = 32'h00000000;
        endcase
        if (!mapped) begin
            rdata_d = 32'h00000000;
        end
    end

    always @(posedge ref_clk) begin
        if (srst) begin
            rdata_q <= 32'h00000000;
        end else if (rd_go) begin
            rdata_q <= rdata_d;
        end
    end
endmodule // uaux_regs

// ==== sim/uaux_props.sv ====
// Checker for uaux_regs reset state, pins and bus answer
// Assumes straps change only outside reset
`timescale 1ns/10ps
module uaux_props (
    input wire       ref_clk, srst, por, avs_read, avs_write, avs_waitrequest,
    input wire [1:0] avs_response,
    input wire       bus_mode_68, irq_drive_select, tx_serial_q, request_to_send_n, terminal_ready_n,
    input wire       rx_dma_ready_n_q, tx_dma_ready_n_q, irq_out, irq_oe, bus68_request_n
);
    a_dma_idle: assert property (@(posedge ref_clk) disable iff (srst) rx_dma_ready_n_q && !tx_dma_ready_n_q)
        else $error("dma ready levels wrong");
    a_rst_tx: assert property (@(posedge ref_clk) disable iff (por) srst |=> tx_serial_q)
        else $error("tx not high after reset");
    a_rst_modem: assert property (@(posedge ref_clk) disable iff (por)
        srst |=> request_to_send_n && terminal_ready_n)
        else $error("modem outputs not high after reset");
    a_rst_irq: assert property (@(posedge ref_clk) disable iff (por)
        srst |=> irq_oe == (!bus_mode_68 && irq_drive_select))
        else $error("irq drive wrong after reset");
    a_por_pins: assert property (@(posedge ref_clk) disable iff (srst) por |=> tx_serial_q && rx_dma_ready_n_q)
        else $error("pins wrong after power-up");
    a_irq_low: assert property (@(posedge ref_clk) disable iff (srst) irq_oe |-> !irq_out)
        else $error("driven irq not low");
    a_req_idle: assert property (@(posedge ref_clk) disable iff (srst) bus_mode_68 |-> bus68_request_n)
        else $error("request pin not high");
    a_wait_one: assert property (@(posedge ref_clk) disable iff (srst)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    a_resp_ok: assert property (@(posedge ref_clk) disable iff (srst)
        (avs_read || avs_write) && !avs_waitrequest |-> avs_response == 2'h0)
        else $error("bad response code");
endmodule // uaux_props
bind uaux_regs uaux_props u_props (.*);

// ==== sim/uaux_modem.sv ====
// Modem-side model: drives the four active-low modem inputs
// Levels come from the bench, held steady through reset
`timescale 1ns/10ps
module uaux_modem (
    // Level request
    input  wire [3:0] lvl,
    // Modem pins
    output wire       clear_to_send_n,
    output wire       set_ready_n,
    output wire       ring_indicator_n,
    output wire       carrier_detect_n
);
    assign {carrier_detect_n, ring_indicator_n, set_ready_n, clear_to_send_n} = lvl;
endmodule // uaux_modem

// ==== sim/uaux_regs_bench.sv ====
// Bench for uaux_regs: register table rows, then resets, irq and straps
// Assumes one-wait Avalon answer; modem pins from uaux_modem
`timescale 1ns/10ps
module uaux_regs_bench;
    reg         ref_clk, srst, por, avs_read, avs_write, bus_mode_68, irq_drive_select;
    reg  [5:0]  avs_address;
    reg  [31:0] avs_writedata;
    reg  [3:0]  lvl;
    reg  [7:0]  rdv;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest, clear_to_send_n, set_ready_n, ring_indicator_n, carrier_detect_n;
    wire        tx_serial_q, request_to_send_n, terminal_ready_n, rx_dma_ready_n_q, tx_dma_ready_n_q;
    wire        irq_oe, bus68_request_n, event_irq, sample_tick_q;
    integer     n_mismatch, total_checks, cyc, i;
    // Rows {index, data or expected, mask}; mask 0 means write
    // reset reads, scratch, divisor, loop
    localparam [679:0] tbl = {20'h100ff, 20'h201ff, 20'h300ff, 20'h400ff, 20'h560ff, 20'h7ffff, 20'h610ff,
        20'ha01ff, 20'hb00ff, 20'h75a00, 20'h75aff, 20'h38000, 20'h001ff, 20'h100ff, 20'h03400, 20'h11200,
        20'h034ff, 20'h112ff, 20'h30000, 20'h100ff, 20'h41800, 20'h68080, 20'h41000, 20'h60080, 20'h40000,
        20'h38000, 20'h034ff, 20'h112ff, 20'h30000, 20'h7ffff, 20'h38000, 20'h001ff, 20'h100ff, 20'h30000};
    uaux_regs uut (.*, .avs_byteenable(4'hf), .avs_response(), .irq_out());
    uaux_modem mdm (.*);
    initial begin
        ref_clk = 0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task results;
        begin
            if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            n_mismatch = n_mismatch + 1;
            results;
        end
    end
    task chk(input [7:0] s, input [7:0] e);
        begin
            total_checks = total_checks + 1;
            if (s !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("CHECK FAILED t=%0t seen %h want %h", $time, s, e);
            end
        end
    endtask
    task bus(input r, input [3:0] ix, input [7:0] d);
        begin
            @(posedge ref_clk);
            avs_read <= r;
            avs_write <= !r;
            avs_address <= {ix, 2'h0};
            avs_writedata <= {24'h0, d};
            @(posedge ref_clk);
            while (avs_waitrequest) @(posedge ref_clk);
            rdv = avs_readdata[7:0];
            avs_read <= 0;
            avs_write <= 0;
        end
    endtask
    task run(input integer lo, input integer hi);
        reg [19:0] r;
        begin
            for (i = lo; i <= hi; i = i + 1) begin
                r = tbl[(33 - i) * 20 +: 20];
                bus(r[7:0] != 8'h0, r[19:16], r[15:8]);
                if (r[7:0] != 8'h0) chk(rdv & r[7:0], r[15:8]);
            end
        end
    endtask
    initial begin
        {srst, por, avs_read, avs_write, bus_mode_68, irq_drive_select} = 6'h30;
        avs_address = 0;
        avs_writedata = 0;
        lvl = 4'he;
        n_mismatch = 0;
        total_checks = 0;
        cyc = 0;
        repeat (4) @(posedge ref_clk);
        srst <= 0;
        por <= 0;
        @(posedge ref_clk);
        chk({tx_serial_q, request_to_send_n, terminal_ready_n, rx_dma_ready_n_q, tx_dma_ready_n_q}, 8'h1e);
        chk({irq_oe, bus68_request_n}, 8'h01);
        run(0, 24);
        // Carrier change raises an unmasked event; clear loopback leftovers first
        bus(0, 8, 8'h02);
        bus(0, 9, 8'h02);
        @(posedge ref_clk);
        chk(event_irq, 0);
        lvl <= 4'h6;
        bus(1, 6, 0);
        chk(rdv & 8'h80, 8'h80);
        chk(event_irq, 1);
        bus(0, 8, 8'h02);
        @(posedge ref_clk);
        chk(event_irq, 0);
        bus(0, 9, 0);
        lvl <= 4'he;
        bus(1, 6, 0);
        chk(rdv & 8'h80, 8'h00);
        bus(1, 8, 0);
        chk({rdv[1], event_irq}, 8'h02);
        bus(0, 8, 8'h02);
        // pin reset keeps divisor, power-up restores it
        @(posedge ref_clk);
        srst <= 1;
        @(posedge ref_clk);
        srst <= 0;
        run(25, 29);
        @(posedge ref_clk);
        por <= 1;
        @(posedge ref_clk);
        por <= 0;
        run(30, 33);
        // Divisor one: tick every cycle, bit event after sixteen ticks
        repeat (20) @(posedge ref_clk);
        chk(sample_tick_q, 1);
        bus(1, 8, 0);
        chk(rdv & 8'h01, 8'h01);
        irq_drive_select <= 1;
        @(posedge ref_clk);
        chk(irq_oe, 1);
        bus_mode_68 <= 1;
        irq_drive_select <= 0;
        @(posedge ref_clk);
        chk({irq_oe, bus68_request_n}, 8'h01);
        results;
    end
endmodule // uaux_regs_bench
